//--- verilog/shp_host.sv
`timescale 1ns/1ns
// Host end: parallel master, SPI pin driver, ROM pin observer
module shp_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Shared pins
  shp_pins_if.host pins,
  // Personality strap
  input wire logic [1:0] mode_sel,
  // Parallel access request
  input wire logic par_req,
  input wire logic par_write,
  input wire logic par_a0,
  input wire logic [7:0] par_wdata,
  output logic par_busy,
  output logic par_done,
  output logic [7:0] par_rdata,
  // SPI master pin levels
  input wire logic spi_cs_n_in,
  input wire logic spi_sclk_in,
  // External interrupt and alternate analog sample
  input wire logic ext_int_level,
  input wire logic [7:0] alt_sample_in,
  // Observed device outputs
  output logic irq_seen,
  output logic rom_cs_n,
  output logic rom_sclk
);

  // All host state
  typedef struct packed {
    shp_pkg::shp_host_state_e state;
    logic [3:0] cnt;
    logic [1:0] mode;
    logic a0;
    logic write;
    logic rd_n;
    logic wr_n;
    logic [7:0] dout;
    logic doe;
    logic csl_o;
    logic csl_oe;
    logic csh_o;
    logic csh_oe;
    logic ext;
    logic [7:0] alt;
    logic busy;
    logic done;
    logic [7:0] rdata;
    logic irq;
    logic rom_cs_n;
    logic rom_sclk;
  } shp_host_s;

  shp_host_s st_reg;
  shp_host_s st_next;
  logic par_mode;

  // Sequencer and pin levels
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.mode = mode_sel;
    st_next.ext = ext_int_level;
    st_next.alt = alt_sample_in;
    st_next.irq = !pins.int_n;
    par_mode = (st_reg.mode == shp_pkg::MODE_PAR);
    // ROM pins seen only when the device masters them
    if (st_reg.mode == shp_pkg::MODE_USB_EXT) begin
      st_next.rom_cs_n = pins.csl;
      st_next.rom_sclk = pins.csh;
    end else begin
      st_next.rom_cs_n = 1'b1;
      st_next.rom_sclk = 1'b1;
    end
    unique case (st_reg.state)
      shp_pkg::HS_IDLE: begin
        st_next.rd_n = 1'b1;
        st_next.wr_n = 1'b1;
        st_next.doe = 1'b0;
        st_next.busy = 1'b0;
        if (st_reg.mode == shp_pkg::MODE_SPI) begin
          st_next.csl_o = spi_cs_n_in;
          st_next.csh_o = spi_sclk_in;
          st_next.csl_oe = 1'b1;
          st_next.csh_oe = 1'b1;
        end else begin
          // Parallel idle keeps the device deselected
          st_next.csl_o = 1'b1;
          st_next.csh_o = 1'b0;
          st_next.csl_oe = par_mode;
          st_next.csh_oe = par_mode;
        end
        if (par_req && par_mode) begin
          st_next.state = shp_pkg::HS_SETUP;
          st_next.busy = 1'b1;
          st_next.a0 = par_a0;
          st_next.write = par_write;
          st_next.dout = par_wdata;
          st_next.csl_o = 1'b0;
          st_next.csh_o = 1'b1;
        end
      end
      shp_pkg::HS_SETUP: begin
        // Selected with address stable; now open the strobe
        st_next.state = shp_pkg::HS_STROBE;
        st_next.cnt = shp_pkg::STROBE_LAST;
        st_next.rd_n = st_reg.write;
        st_next.wr_n = !st_reg.write;
        st_next.doe = st_reg.write;
      end
      shp_pkg::HS_STROBE: begin
        if (st_reg.cnt == 4'h0) begin
          st_next.state = shp_pkg::HS_HOLD;
          st_next.rd_n = 1'b1;
          st_next.wr_n = 1'b1;
          if (!st_reg.write) begin
            st_next.rdata = pins.d;
          end
        end else begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end
      end
      shp_pkg::HS_HOLD: begin
        // Data and select outlast the strobe's rising edge
        st_next.state = shp_pkg::HS_IDLE;
        st_next.doe = 1'b0;
        st_next.csl_o = 1'b1;
        st_next.csh_o = 1'b0;
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
      default: begin
        st_next.state = shp_pkg::HS_IDLE;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.state <= shp_pkg::HS_IDLE;
      st_reg.rd_n <= 1'b1;
      st_reg.wr_n <= 1'b1;
      st_reg.csl_o <= 1'b1;
      st_reg.ext <= 1'b1;
      st_reg.rom_cs_n <= 1'b1;
      st_reg.rom_sclk <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pin and user outputs, all from flops
  assign pins.mode = st_reg.mode;
  assign pins.idx_sel = st_reg.a0;
  assign pins.rd_n = st_reg.rd_n;
  assign pins.wr_n = st_reg.wr_n;
  assign pins.host_d_o = st_reg.dout;
  assign pins.host_d_oe = st_reg.doe;
  assign pins.csl_host_o = st_reg.csl_o;
  assign pins.csl_host_oe = st_reg.csl_oe;
  assign pins.csh_host_o = st_reg.csh_o;
  assign pins.csh_host_oe = st_reg.csh_oe;
  assign pins.ext_int = st_reg.ext;
  assign pins.alt_sample = st_reg.alt;
  assign par_busy = st_reg.busy;
  assign par_done = st_reg.done;
  assign par_rdata = st_reg.rdata;
  assign irq_seen = st_reg.irq;
  assign rom_cs_n = st_reg.rom_cs_n;
  assign rom_sclk = st_reg.rom_sclk;

endmodule : shp_host

//--- verilog/shp_pkg.sv
// Shared constants for the sensor host pin function mux
package shp_pkg;
  // Width of the parallel data bus and index register
  localparam int unsigned DATA_W = 8;
  // Interface select encodings
  localparam logic [1:0] MODE_PAR = 2'h0;
  localparam logic [1:0] MODE_SPI = 2'h1;
  localparam logic [1:0] MODE_USB_INT = 2'h2;
  localparam logic [1:0] MODE_USB_EXT = 2'h3;
  // Reset values
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [7:0] KEEP_RST = 8'h00;
  // Host strobe width, a least time
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STROBE_NS = 30;
  localparam int unsigned STROBE_CYC =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
  // Host sequencer states
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_SETUP,
    HS_STROBE,
    HS_HOLD
  } shp_host_state_e;
endpackage : shp_pkg

//--- verilog/shp_pins_if.sv
`timescale 1ns/1ns
// Shared host-side pins; resolves each two-way wire from its enables
interface shp_pins_if;
  // Mode straps and parallel control
  logic [1:0] mode;
  logic idx_sel;
  logic rd_n;
  logic wr_n;
  // Parallel data bus drivers and resolved level
  logic [7:0] host_d_o;
  logic host_d_oe;
  logic [7:0] dev_d_o;
  logic dev_d_oe;
  logic [7:0] dev_d_keep;
  logic [7:0] d;
  // Low-active chip select / slave select pin
  logic csl_host_o;
  logic csl_host_oe;
  logic csl_dev_o;
  logic csl_dev_oe;
  logic csl;
  // High-active chip select / serial clock pin
  logic csh_host_o;
  logic csh_host_oe;
  logic csh_dev_o;
  logic csh_dev_oe;
  logic csh;
  // Interrupts and alternate analog sample
  logic ext_int;
  logic int_dev_o;
  logic int_dev_oe;
  logic int_n;
  logic [7:0] alt_sample;

  // Undriven data lines fall back to the device's hold latch
  assign d = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : dev_d_keep);
  // Select pins have pull-ups
  assign csl = csl_dev_oe ? csl_dev_o : (csl_host_oe ? csl_host_o : 1'b1);
  assign csh = csh_dev_oe ? csh_dev_o : (csh_host_oe ? csh_host_o : 1'b1);
  // Open-drain interrupt with pull-up
  assign int_n = int_dev_oe ? int_dev_o : 1'b1;

  modport dev (
    input mode, idx_sel, rd_n, wr_n, d, csl, csh, ext_int, alt_sample,
    output dev_d_o, dev_d_oe, dev_d_keep, csl_dev_o, csl_dev_oe,
    output csh_dev_o, csh_dev_oe, int_dev_o, int_dev_oe
  );
  modport host (
    output mode, idx_sel, rd_n, wr_n, host_d_o, host_d_oe,
    output csl_host_o, csl_host_oe, csh_host_o, csh_host_oe,
    output ext_int, alt_sample,
    input d, csl, csh, int_n
  );
endinterface : shp_pins_if

//--- verilog/shp_device.sv
// What this block does
// - Two-bit select picks one of four personalities
// - Index select low: index, high: indexed data
// - Host reads with read low, write high
// - Host writes with write low, read high
// - Parallel: selected when low CS low, high CS high
// - SPI: low select pin is slave select
// - SPI: high select pin is serial clock
// - USB internal ROM: both select pins ignored
// - USB external ROM: drive ROM select out
// - USB external ROM: drive ROM clock out
// - External interrupt edge/level, either polarity
// - Interrupt pin floats idle, low when pending
// - Interrupt pin only in parallel or SPI
// - Analog select routes alternate input to converter
// - Hold latch keeps last bus level undriven
// - Index register kept until rewritten or reset
`timescale 1ns/1ns
module shp_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Shared pins
  shp_pins_if.dev pins,
  // Register access toward the core
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  // SPI slave pins passed to the serial engine
  output logic spi_en,
  output logic spi_cs_n,
  output logic spi_sclk,
  // Serial ROM master from the USB engine
  input wire logic rom_cs_n,
  input wire logic rom_sclk,
  // Interrupt control
  input wire logic irq_enable,
  input wire logic ext_edge_mode,
  input wire logic ext_active_high,
  input wire logic irq_event,
  input wire logic irq_clear,
  output logic irq_pending,
  // Converter input selection
  input wire logic analog_input_select,
  input wire logic [7:0] sensor_sample,
  output logic [7:0] conv_sample
);

  // All state of the pin mux
  typedef struct packed {
    logic [7:0] index;     // Address index register
    logic [7:0] dout;      // Data driven on reads
    logic doe;             // Data bus driver enable
    logic [7:0] keep;      // Hold latch for the data bus
    logic wr_act;          // Write strobe seen active last cycle
    logic wr_a0;           // Index select captured during write
    logic [7:0] wr_data;   // Data captured during write
    logic rd_act;          // Read strobe seen active last cycle
    logic reg_wr;          // Data register write pulse
    logic reg_rd;          // Data register read start pulse
    logic [7:0] reg_wdata; // Data for the core register
    logic spi_en;          // SPI personality active
    logic spi_cs_n;        // Slave select toward serial engine
    logic spi_sclk;        // Serial clock toward serial engine
    logic csl_o;           // Low select pin output value
    logic csl_oe;          // Low select pin driver enable
    logic csh_o;           // High select pin output value
    logic csh_oe;          // High select pin driver enable
    logic ext_prev;        // External interrupt activity, last cycle
    logic pending;         // Interrupt pending flag
    logic int_oe;          // Interrupt pin pulls low
    logic [7:0] conv;      // Converter input sample
  } shp_dev_s;

  shp_dev_s st_reg;
  shp_dev_s st_next;

  // Decoded personality and pin terms
  logic is_par;
  logic is_spi;
  logic is_rom;
  logic selected;
  logic rd_now;
  logic wr_now;
  logic ext_act;
  logic ext_set;

  // Mode decode and parallel port decode
  always_comb begin
    is_par = (pins.mode == shp_pkg::MODE_PAR);
    is_spi = (pins.mode == shp_pkg::MODE_SPI);
    is_rom = (pins.mode == shp_pkg::MODE_USB_EXT);
    // Both select pins decode a selection only in parallel mode
    selected = is_par && !pins.csl && pins.csh;
    rd_now = selected && !pins.rd_n && pins.wr_n;
    wr_now = selected && !pins.wr_n && pins.rd_n;
    // Polarity applied before any edge logic
    ext_act = ext_active_high ? pins.ext_int : !pins.ext_int;
    if (ext_edge_mode) begin
      // Edge mode: one set per inactive-to-active change
      ext_set = ext_act && !st_reg.ext_prev;
    end else begin
      // Level mode: sets every cycle the input is active
      ext_set = ext_act;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    st_next.reg_wr = 1'b0;
    st_next.reg_rd = 1'b0;

    // Hold latch follows the resolved bus; with no driver it
    // sees its own value back, so the level simply persists
    st_next.keep = pins.d;

    // Read: drive index or indexed data while the read lasts
    st_next.doe = rd_now;
    if (rd_now) begin
      st_next.dout = pins.idx_sel ? reg_rdata : st_reg.index;
    end
    st_next.rd_act = rd_now;
    if (rd_now && !st_reg.rd_act && pins.idx_sel) begin
      // Tell the core a data read has begun
      st_next.reg_rd = 1'b1;
    end

    // Write: capture while low, commit on the strobe's rising edge
    st_next.wr_act = wr_now;
    if (wr_now) begin
      st_next.wr_a0 = pins.idx_sel;
      st_next.wr_data = pins.d;
    end
    if (st_reg.wr_act && !wr_now) begin
      if (st_reg.wr_a0) begin
        // Data buffer of the indexed register
        st_next.reg_wr = 1'b1;
        st_next.reg_wdata = st_reg.wr_data;
      end else begin
        // Only a write here changes the index
        st_next.index = st_reg.wr_data;
      end
    end

    // SPI slave pins; forced idle outside SPI mode
    st_next.spi_en = is_spi;
    st_next.spi_cs_n = is_spi ? pins.csl : 1'b1;
    st_next.spi_sclk = is_spi ? pins.csh : 1'b0;

    // Select pins become ROM master outputs only in mode 11b;
    // in every other mode the device never drives them
    st_next.csl_oe = is_rom;
    st_next.csh_oe = is_rom;
    st_next.csl_o = is_rom ? rom_cs_n : 1'b1;
    st_next.csh_o = is_rom ? rom_sclk : 1'b1;
    // Mode 10b: nothing above reads or drives the select pins

    // Pending flag: a set in the clearing cycle wins
    st_next.ext_prev = ext_act;
    st_next.pending = ext_set || irq_event ||
                      (st_reg.pending && !irq_clear);
    // Pin pulls low only for an enabled event, and only in
    // parallel or SPI mode; USB modes leave it floating
    st_next.int_oe = (is_par || is_spi) && irq_enable &&
                     st_reg.pending;

    // Converter input mux
    if (analog_input_select) begin
      st_next.conv = pins.alt_sample;
    end else begin
      st_next.conv = sensor_sample;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.index <= shp_pkg::INDEX_RST;
      st_reg.keep <= shp_pkg::KEEP_RST;
      st_reg.spi_cs_n <= 1'b1;
      st_reg.csl_o <= 1'b1;
      st_reg.csh_o <= 1'b1;
      // An input already active at reset is not taken as an edge
      st_reg.ext_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pin drivers from flops, except the interrupt level, which is a constant
  assign pins.dev_d_o = st_reg.dout;
  assign pins.dev_d_oe = st_reg.doe;
  assign pins.dev_d_keep = st_reg.keep;
  assign pins.csl_dev_o = st_reg.csl_o;
  assign pins.csl_dev_oe = st_reg.csl_oe;
  assign pins.csh_dev_o = st_reg.csh_o;
  assign pins.csh_dev_oe = st_reg.csh_oe;
  // Open drain: the only driven level is low
  assign pins.int_dev_o = 1'b0;
  assign pins.int_dev_oe = st_reg.int_oe;

  // Core-side outputs, all from flops
  assign reg_addr = st_reg.index;
  assign reg_wdata = st_reg.reg_wdata;
  assign reg_wr = st_reg.reg_wr;
  assign reg_rd = st_reg.reg_rd;
  assign spi_en = st_reg.spi_en;
  assign spi_cs_n = st_reg.spi_cs_n;
  assign spi_sclk = st_reg.spi_sclk;
  assign irq_pending = st_reg.pending;
  assign conv_sample = st_reg.conv;

endmodule : shp_device

//--- tb/shp_pins_properties.sv
`timescale 1ns/1ns
// Pin-level checks between the device and host ends
module shp_pins_properties (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Watched wires
  input logic [1:0] mode,
  input logic rd_n,
  input logic wr_n,
  input logic csl,
  input logic csh,
  input logic [7:0] d,
  input logic dev_d_oe,
  input logic [7:0] dev_d_keep,
  input logic csl_dev_oe,
  input logic csh_dev_oe,
  input logic int_dev_o,
  input logic int_dev_oe
);
  // Selected read strobe on the pins in this cycle
  logic rd_sel;
  assign rd_sel = mode == shp_pkg::MODE_PAR && !csl && csh &&
    !rd_n && wr_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rd_drives_bus: assert property (rd_sel |=> dev_d_oe)
    else $error("device did not drive a selected read");
  a_bus_released: assert property (!rd_sel |=> !dev_d_oe)
    else $error("device drove the bus outside a read");
  a_bus_mode_off: assert property (
    mode != shp_pkg::MODE_PAR |=> !dev_d_oe)
    else $error("device drove the bus outside parallel mode");
  // Latch follows the wire one cycle late
  a_keep_follows: assert property (1'b1 |=> dev_d_keep == $past(d))
    else $error("hold latch lost the bus level");
  a_rom_drive_on: assert property (mode == shp_pkg::MODE_USB_EXT
    |=> csl_dev_oe && csh_dev_oe)
    else $error("select pins not driven toward the ROM");
  a_sel_pins_free: assert property (mode != shp_pkg::MODE_USB_EXT
    |=> !csl_dev_oe && !csh_dev_oe)
    else $error("select pins driven outside ROM mode");
  // Both USB personalities have the high mode bit set
  a_int_usb_off: assert property (mode[1] |=> !int_dev_oe)
    else $error("interrupt pin driven in a USB mode");
  a_int_drive_low: assert property (int_dev_oe |-> !int_dev_o)
    else $error("interrupt pin driven high");
endmodule : shp_pins_properties

//--- tb/sensor_host_pin_function_mux_test.sv
`timescale 1ns/1ns
// Counts a comparison and reports a mismatch at once
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  num_errors++; $display("mismatch %s expected %h seen %h", nm, ex, got); \
  end end
module sensor_host_pin_function_mux_test;
  // Clock, reset and counters
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int checks = 0;
  int num_errors = 0;
  int rd_pulses = 0;
  // Device-side stimulus
  logic [7:0] reg_rdata = 8'h3c;
  logic [7:0] sensor_sample = 8'h11;
  logic rom_cs_n = 1'b1, rom_sclk = 1'b1, irq_enable = 1'b1;
  logic ext_edge_mode = 1'b0, ext_active_high = 1'b0;
  logic irq_event = 1'b0, irq_clear = 1'b0, analog_input_select = 1'b0;
  // Host-side stimulus
  logic [1:0] mode_sel = shp_pkg::MODE_PAR;
  logic par_req = 1'b0, par_write = 1'b0, par_a0 = 1'b0;
  logic [7:0] par_wdata = 8'h00, alt_sample_in = 8'h22;
  logic spi_cs_n_in = 1'b1, spi_sclk_in = 1'b0, ext_int_level = 1'b1;
  // Observed outputs; wr_* hold the last core write
  logic [7:0] reg_addr, reg_wdata, conv_sample, par_rdata, wr_data, wr_addr;
  logic reg_wr, reg_rd, spi_en, spi_cs_n, spi_sclk, irq_pending;
  logic par_busy, par_done, irq_seen, h_rom_cs_n, h_rom_sclk;

  shp_pins_if u_shp_pins_if ();
  shp_device u_shp_device (.clk(clk), .rst_n(rst_n), .pins(u_shp_pins_if),
    .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .spi_en(spi_en),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .rom_cs_n(rom_cs_n),
    .rom_sclk(rom_sclk), .irq_enable(irq_enable),
    .ext_edge_mode(ext_edge_mode), .ext_active_high(ext_active_high),
    .irq_event(irq_event), .irq_clear(irq_clear),
    .irq_pending(irq_pending), .analog_input_select(analog_input_select),
    .sensor_sample(sensor_sample), .conv_sample(conv_sample));
  shp_host u_shp_host (.clk(clk), .rst_n(rst_n), .pins(u_shp_pins_if),
    .mode_sel(mode_sel), .par_req(par_req), .par_write(par_write),
    .par_a0(par_a0), .par_wdata(par_wdata), .par_busy(par_busy),
    .par_done(par_done), .par_rdata(par_rdata),
    .spi_cs_n_in(spi_cs_n_in), .spi_sclk_in(spi_sclk_in),
    .ext_int_level(ext_int_level), .alt_sample_in(alt_sample_in),
    .irq_seen(irq_seen), .rom_cs_n(h_rom_cs_n), .rom_sclk(h_rom_sclk));
  shp_pins_properties u_props (.clk(clk), .rst_n(rst_n),
    .mode(u_shp_pins_if.mode), .rd_n(u_shp_pins_if.rd_n),
    .wr_n(u_shp_pins_if.wr_n), .csl(u_shp_pins_if.csl),
    .csh(u_shp_pins_if.csh), .d(u_shp_pins_if.d),
    .dev_d_oe(u_shp_pins_if.dev_d_oe),
    .dev_d_keep(u_shp_pins_if.dev_d_keep),
    .csl_dev_oe(u_shp_pins_if.csl_dev_oe),
    .csh_dev_oe(u_shp_pins_if.csh_dev_oe),
    .int_dev_o(u_shp_pins_if.int_dev_o),
    .int_dev_oe(u_shp_pins_if.int_dev_oe));

  // 100 MHz clock
  always #5 clk = ~clk;
  // Capture core-side pulses, which last one cycle only
  always @(posedge clk) begin
    if (reg_wr === 1'b1) begin
      wr_data <= reg_wdata;
      wr_addr <= reg_addr;
    end
    if (reg_rd === 1'b1) rd_pulses <= rd_pulses + 1;
  end

  // Verdict and end of run
  task results;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  // One parallel access through the host end, bounded wait for done
  task par(input logic wr, input logic a0, input logic [7:0] wd);
    int i;
    @(posedge clk);
    par_req <= 1'b1;
    par_write <= wr;
    par_a0 <= a0;
    par_wdata <= wd;
    @(posedge clk);
    par_req <= 1'b0;
    for (i = 0; i < 20 && par_done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (par_done !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask : par
  // Bounded wait for the interrupt wire to reach a level
  task wait_int(input logic lvl);
    int i;
    // Look a little after each edge, once the flops have settled
    #1;
    for (i = 0; i < 20 && u_shp_pins_if.int_n !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
    if (u_shp_pins_if.int_n !== lvl) begin
      num_errors++;
      results();
    end
  endtask : wait_int
  task set_mode(input logic [1:0] m);
    @(posedge clk);
    mode_sel <= m;
    step(3);
  endtask : set_mode
  // One-cycle event (clr=0) or clear (clr=1)
  task pulse(input logic clr);
    @(posedge clk);
    if (clr) irq_clear <= 1'b1;
    else irq_event <= 1'b1;
    @(posedge clk);
    irq_clear <= 1'b0;
    irq_event <= 1'b0;
  endtask : pulse

  // Index write, data write and read, index readback, bus hold
  task t_parallel;
    par(1'b1, 1'b0, 8'h5a);
    par(1'b1, 1'b1, 8'hc3);
    step(3);
    #1;
    `CHK("wdata", 8'hc3, wr_data);
    `CHK("waddr", 8'h5a, wr_addr);
    par(1'b0, 1'b1, 8'h00);
    `CHK("data read", 8'h3c, par_rdata);
    par(1'b0, 1'b0, 8'h00);
    `CHK("index read", 8'h5a, par_rdata);
    `CHK("rd pulses", 1, rd_pulses);
    step(3);
    #1;
    `CHK("bus hold", 8'h5a, u_shp_pins_if.d);
  endtask : t_parallel
  // SPI slave select and clock follow the pins
  task t_spi;
    set_mode(shp_pkg::MODE_SPI);
    spi_cs_n_in <= 1'b0;
    spi_sclk_in <= 1'b1;
    step(3);
    #1;
    `CHK("spi en", 1'b1, spi_en);
    `CHK("spi cs", 1'b0, spi_cs_n);
    `CHK("spi clk", 1'b1, spi_sclk);
    @(posedge clk);
    spi_cs_n_in <= 1'b1;
    spi_sclk_in <= 1'b0;
    step(3);
    #1;
    `CHK("spi cs off", 1'b1, spi_cs_n);
    `CHK("spi clk low", 1'b0, spi_sclk);
  endtask : t_spi
  // ROM select and clock driven out, then internal ROM leaves pins free
  task t_usb;
    set_mode(shp_pkg::MODE_USB_EXT);
    rom_cs_n <= 1'b0;
    step(3);
    #1;
    `CHK("rom cs", 1'b0, u_shp_pins_if.csl);
    `CHK("rom clk", 1'b1, h_rom_sclk);
    @(posedge clk);
    rom_sclk <= 1'b0;
    step(3);
    #1;
    `CHK("rom clk low", 1'b0, u_shp_pins_if.csh);
    `CHK("rom cs seen", 1'b0, h_rom_cs_n);
    set_mode(shp_pkg::MODE_USB_INT);
    #1;
    `CHK("csl free", 1'b1, u_shp_pins_if.csl);
    `CHK("csh free", 1'b1, u_shp_pins_if.csh);
    `CHK("spi cs idle", 1'b1, spi_cs_n);
    pulse(1'b0);
    step(4);
    #1;
    `CHK("usb pending", 1'b1, irq_pending);
    `CHK("usb int pin", 1'b1, u_shp_pins_if.int_n);
    pulse(1'b1);
  endtask : t_usb
  // Event, enable gating, external level and edge detection
  task t_irq;
    set_mode(shp_pkg::MODE_PAR);
    pulse(1'b0);
    wait_int(1'b0);
    // The host samples the wire one cycle after it falls
    step(1);
    #1;
    `CHK("irq seen", 1'b1, irq_seen);
    pulse(1'b1);
    wait_int(1'b1);
    @(posedge clk);
    irq_enable <= 1'b0;
    pulse(1'b0);
    step(4);
    #1;
    `CHK("masked pin", 1'b1, u_shp_pins_if.int_n);
    `CHK("masked pend", 1'b1, irq_pending);
    // Clear before enabling, so the pin only falls for the input
    pulse(1'b1);
    @(posedge clk);
    irq_enable <= 1'b1;
    ext_int_level <= 1'b0;
    wait_int(1'b0);
    @(posedge clk);
    ext_int_level <= 1'b1;
    pulse(1'b1);
    wait_int(1'b1);
    @(posedge clk);
    ext_edge_mode <= 1'b1;
    ext_active_high <= 1'b1;
    ext_int_level <= 1'b0;
    step(3);
    pulse(1'b1);
    wait_int(1'b1);
    @(posedge clk);
    ext_int_level <= 1'b1;
    wait_int(1'b0);
    pulse(1'b1);
    step(4);
    #1;
    // A held level must not set pending again in edge mode
    `CHK("edge once", 1'b1, u_shp_pins_if.int_n);
  endtask : t_irq
  // Converter input choice, then a reset in mid-run
  task t_analog_reset;
    step(3);
    #1;
    `CHK("sensor in", 8'h11, conv_sample);
    @(posedge clk);
    analog_input_select <= 1'b1;
    step(3);
    #1;
    `CHK("alt in", 8'h22, conv_sample);
    @(posedge clk);
    rst_n <= 1'b0;
    step(3);
    rst_n <= 1'b1;
    step(2);
    #1;
    `CHK("index rst", shp_pkg::INDEX_RST, reg_addr);
    `CHK("keep rst", shp_pkg::KEEP_RST, u_shp_pins_if.d);
    par(1'b0, 1'b0, 8'h00);
    `CHK("index after rst", shp_pkg::INDEX_RST, par_rdata);
  endtask : t_analog_reset

  // Main sequence
  initial begin
    step(3);
    rst_n <= 1'b1;
    step(2);
    t_parallel();
    t_spi();
    t_usb();
    t_irq();
    t_analog_reset();
    results();
  end
endmodule : sensor_host_pin_function_mux_test
